// ==== rtl/fcq_host.sv ====
// Host controller that drives a parallel NOR flash over its pins:
// query entry and exit, query reads, unlocked program, and the
// elevated clear-pin request for temporary block unprotect.
// Assumes board logic turns clear_elevated_req into the high voltage.
//
// Summary of operation
// - Elevated clear pin lets protected block groups be programmed or erased.
// - Query entry writes 98h at 55h word or AAh byte mode.
// - Word-mode query reads hold address bit seven and above at zero.
// - Reset command leaves query entered from array read.
// - Query allowed from autoselect; reset then returns to autoselect.
// - Program starts only after the unlock write cycles precede it.
module fcq_host
   import fcq_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              nrst,
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire fcq_op_type        req_op,
   input  wire logic [19:0]       req_addr,
   input  wire logic [15:0]       req_wdata,
   input  wire logic              byte_mode,
   input  wire logic              unprotect_req,
   output logic                   rsp_valid,
   output logic [15:0]            rsp_rdata,
   output logic                   clear_elevated_req,
   output logic [19:0]            flash_addr,
   output logic [15:0]            flash_dq_o,
   output logic                   flash_dq_oe,
   input  wire logic [15:0]       flash_dq_i,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n
);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_RD    = 3'b001,
      ST_WR    = 3'b010,
      ST_WGAP  = 3'b011,
      ST_DONE  = 3'b100
   } fcq_state_type;

   typedef struct packed {
      fcq_state_type st;
      logic [2:0]    cnt;
      logic [1:0]    step;
      logic [1:0]    nsteps;
      logic          rd;
      logic [19:0]   addr;
      logic [15:0]   dout;
      logic [19:0]   tgt_addr;
      logic [15:0]   tgt_data;
      logic          oe_n;
      logic          we_n;
      logic          ce_n;
      logic          dq_oe;
      logic          rsp;
      logic [15:0]   rdata;
      logic          elev;
      logic          qry;      // Host copy of query mode, for address masking
   } fcq_regs_type;

   fcq_regs_type r_q, r_d;
   logic [15:0]  dq_s;
   logic         unprot_s;

   // Data pins and strap-like request come from outside the clock
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_dq
         fcq_sync u_dq (.ref_clk(ref_clk), .nrst(nrst), .async_in(flash_dq_i[gi]), .sync_out(dq_s[gi]));
      end
   endgenerate
   fcq_sync u_unp (.ref_clk(ref_clk), .nrst(nrst), .async_in(unprotect_req), .sync_out(unprot_s));

   // Unlock address for a given step
   function automatic logic [19:0] unlock_addr(input logic s, input logic bm);
      if (s == 1'b0) unlock_addr = bm ? ADDR_UNLOCK1_BYTE : ADDR_UNLOCK1_WORD;
      else unlock_addr = bm ? ADDR_UNLOCK2_BYTE : ADDR_UNLOCK2_WORD;
   endfunction

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      r_d     = r_q;
      r_d.rsp = 1'b0;
      r_d.elev = unprot_s;
      unique case (r_q.st)
         ST_IDLE: begin
            r_d.ce_n = 1'b1;
            r_d.oe_n = 1'b1;
            r_d.we_n = 1'b1;
            r_d.dq_oe = 1'b0;
            if (req_valid) begin
               r_d.cnt  = '0;
               r_d.step = '0;
               r_d.nsteps = '0;
               r_d.rd   = 1'b0;
               unique case (req_op)
                  FCQ_OP_READ: begin
                     // Upper bits forced low in word-mode query, array reads untouched
                     r_d.addr = (r_q.qry && !byte_mode) ? (req_addr & QUERY_ADDR_MASK) : req_addr;
                     r_d.rd = 1'b1;
                  end
                  FCQ_OP_QUERY: begin
                     // Entry allowed from array read or autoselect
                     r_d.addr = byte_mode ? ADDR_QUERY_BYTE : ADDR_QUERY_WORD;
                     r_d.dout = {8'h00, CMD_QUERY};
                     r_d.qry  = 1'b1;
                  end
                  FCQ_OP_RESET: begin
                     r_d.addr = req_addr;
                     r_d.dout = {8'h00, CMD_RESET};
                     r_d.qry  = 1'b0;
                  end
                  FCQ_OP_PROGRAM: begin
                     // Two unlock writes, the program command, then data
                     r_d.addr = unlock_addr(1'b0, byte_mode);
                     r_d.dout = {8'h00, CMD_UNLOCK1};
                     r_d.nsteps = 2'd3;
                     r_d.tgt_addr = req_addr;
                     r_d.tgt_data = req_wdata;
                  end
                  default: begin
                     r_d.addr = req_addr;
                     r_d.dout = req_wdata;
                  end
               endcase
               r_d.st = r_d.rd ? ST_RD : ST_WR;
            end
         end
         ST_RD: begin
            // Read: address then strobes, sample after access time
            r_d.ce_n = 1'b0;
            r_d.oe_n = 1'b0;
            r_d.cnt  = r_q.cnt + 3'd1;
            if (r_q.cnt == 3'(ACCESS_CYCLES + 2)) begin
               r_d.rdata = dq_s;
               r_d.rsp   = 1'b1;
               r_d.oe_n  = 1'b1;
               r_d.ce_n  = 1'b1;
               r_d.st    = ST_DONE;
            end
         end
         ST_WR: begin
            r_d.ce_n  = 1'b0;
            r_d.we_n  = 1'b0;
            r_d.dq_oe = 1'b1;
            r_d.cnt   = r_q.cnt + 3'd1;
            if (r_q.cnt == 3'(STROBE_CYCLES)) begin
               r_d.we_n = 1'b1;
               r_d.ce_n = 1'b1;
               r_d.cnt  = '0;
               r_d.st   = ST_WGAP;
            end
         end
         ST_WGAP: begin
            r_d.cnt = r_q.cnt + 3'd1;
            if (r_q.cnt == 3'd1) begin
               r_d.dq_oe = 1'b0;
               r_d.cnt = '0;
               if (r_q.step == r_q.nsteps) begin
                  r_d.rsp = 1'b1;
                  r_d.st  = ST_DONE;
               end else begin
                  r_d.step = r_q.step + 2'd1;
                  r_d.st   = ST_WR;
                  unique case (r_q.step)
                     2'd0: begin
                        r_d.addr = unlock_addr(1'b1, byte_mode);
                        r_d.dout = {8'h00, CMD_UNLOCK2};
                     end
                     2'd1: begin
                        r_d.addr = unlock_addr(1'b0, byte_mode);
                        r_d.dout = 16'h00a0;
                     end
                     default: begin
                        r_d.addr = r_q.tgt_addr;
                        r_d.dout = r_q.tgt_data;
                     end
                  endcase
               end
            end
         end
         ST_DONE: r_d.st = ST_IDLE;
         default: r_d.st = ST_IDLE;
      endcase
   end

   // ****************************************************************
   // Register
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         r_q <= '{st: ST_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
      end else begin
         r_q <= r_d;
      end
   end

   // Outputs: address held steady between accesses, which lets the
   // device drop into its low-power sleep on its own
   assign req_ready          = (r_q.st == ST_IDLE);
   assign rsp_valid          = r_q.rsp;
   assign rsp_rdata          = r_q.rdata;
   assign clear_elevated_req = r_q.elev;
   assign flash_addr         = r_q.addr;
   assign flash_dq_o         = r_q.dout;
   assign flash_dq_oe        = r_q.dq_oe;
   assign flash_ce_n         = r_q.ce_n;
   assign flash_oe_n         = r_q.oe_n;
   assign flash_we_n         = r_q.we_n;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_no_contention;
      @(posedge ref_clk) disable iff (!nrst) flash_dq_oe |-> flash_oe_n;
   endproperty
   a_no_contention: assert property (p_no_contention) else $error("dq driven while oe low");

   property p_rd_no_we;
      @(posedge ref_clk) disable iff (!nrst) (r_q.st == ST_RD) |-> flash_we_n;
   endproperty
   a_rd_no_we: assert property (p_rd_no_we) else $error("write strobe during read");

   property p_unprot_follow;
      @(posedge ref_clk) disable iff (!nrst) $rose(unprotect_req) |-> ##[2:4] clear_elevated_req;
   endproperty
   a_unprot_follow: assert property (p_unprot_follow) else $error("unprotect not forwarded");

   property p_query_addr;
      @(posedge ref_clk) disable iff (!nrst)
         (req_valid && req_ready && req_op == FCQ_OP_QUERY && !byte_mode) |=> (flash_addr == ADDR_QUERY_WORD);
   endproperty
   a_query_addr: assert property (p_query_addr) else $error("query address wrong");

   property p_prog_unlock;
      @(posedge ref_clk) disable iff (!nrst)
         (req_valid && req_ready && req_op == FCQ_OP_PROGRAM) |=> (flash_dq_o == {8'h00, CMD_UNLOCK1});
   endproperty
   a_prog_unlock: assert property (p_prog_unlock) else $error("program without unlock");

   property p_rd_addr_low;
      @(posedge ref_clk) disable iff (!nrst)
         (req_valid && req_ready && req_op == FCQ_OP_READ && !byte_mode && r_q.qry)
         |=> (flash_addr[19:7] == 13'h0);
   endproperty
   a_rd_addr_low: assert property (p_rd_addr_low) else $error("upper address bits set");

   property p_rd_rsp;
      @(posedge ref_clk) disable iff (!nrst)
         (req_valid && req_ready && req_op == FCQ_OP_READ) |-> ##[5:7] rsp_valid;
   endproperty
   a_rd_rsp: assert property (p_rd_rsp) else $error("read answer late");

   property p_reset_cmd;
      @(posedge ref_clk) disable iff (!nrst)
         (req_valid && req_ready && req_op == FCQ_OP_RESET) |=> (flash_dq_o == {8'h00, CMD_RESET});
   endproperty
   a_reset_cmd: assert property (p_reset_cmd) else $error("reset command wrong");
endmodule // fcq_host

// ==== include/fcq_pkg.sv ====
// Package for the flash query and unprotect host controller.
// Assumes a 25 MHz ref_clk and an asynchronous parallel NOR flash.
package fcq_pkg;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned CLK_PERIOD_NS     = 40;
   localparam int unsigned ACCESS_TIME_NS    = 70;
   localparam int unsigned SLEEP_EXTRA_NS    = 30;
   localparam int unsigned STROBE_NS         = 80;
   localparam int unsigned ACCESS_CYCLES     = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STROBE_CYCLES     = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SLEEP_CYCLES      =
      (ACCESS_TIME_NS + SLEEP_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ****************************************************************
   // Bus widths and command values
   // ****************************************************************
   localparam int unsigned ADDR_W            = 20;
   localparam int unsigned DATA_W            = 16;
   localparam logic [7:0]  CMD_QUERY         = 8'h98;
   localparam logic [7:0]  CMD_RESET         = 8'hf0;
   localparam logic [7:0]  CMD_UNLOCK1       = 8'haa;
   localparam logic [7:0]  CMD_UNLOCK2       = 8'h55;
   localparam logic [19:0] ADDR_QUERY_WORD   = 20'h00055;
   localparam logic [19:0] ADDR_QUERY_BYTE   = 20'h000aa;
   localparam logic [19:0] ADDR_UNLOCK1_WORD = 20'h00555;
   localparam logic [19:0] ADDR_UNLOCK2_WORD = 20'h002aa;
   localparam logic [19:0] ADDR_UNLOCK1_BYTE = 20'h00aaa;
   localparam logic [19:0] ADDR_UNLOCK2_BYTE = 20'h00555;
   localparam logic [19:0] QUERY_ADDR_MASK   = 20'h0007f;
   // ****************************************************************
   // Request kinds
   // ****************************************************************
   typedef enum logic [2:0] {
      FCQ_OP_READ       = 3'b000,
      FCQ_OP_QUERY      = 3'b001,
      FCQ_OP_RESET      = 3'b010,
      FCQ_OP_PROGRAM    = 3'b011,
      FCQ_OP_WRITE_RAW  = 3'b100
   } fcq_op_type;
endpackage

// ==== rtl/fcq_sync.sv ====
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the input changes slowly compared with ref_clk.
module fcq_sync (
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_q;

   // ****************************************************************
   // Two flops; only the second is read outside
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         meta_q   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // fcq_sync

// ==== bench/fcq_flash_model.sv ====
// Behavioural parallel NOR flash: array, autoselect, query table, protection.
// Assumes flash_addr is a word address, or a byte address in byte mode.
module fcq_flash_model
   import fcq_pkg::*;
#(
   parameter logic [31:0] PROT_MASK = 32'h00000002,
   parameter logic [15:0] AUTO_CODE = 16'h00c3  // Arbitrary autoselect code
) (
   input  wire logic [19:0] addr,
   input  wire logic [15:0] dq_in,
   output logic      [15:0] dq_out,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        byte_mode,
   input  wire logic        clear_hi
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************************************
   // Device state
   // ****************************************************************
   typedef enum logic [1:0] {FCQ_ARRAY, FCQ_AUTO, FCQ_QUERY} fcq_mode_type;
   fcq_mode_type mode      = FCQ_ARRAY;
   logic         back_auto = 1'b0;
   logic         wr_act    = 1'b0;
   logic         asleep    = 1'b0;
   int           unl       = 0;
   int           n_wr      = 0;
   time          t_chg     = 0;
   logic [6:0]   w;
   logic [19:0]  u1;
   logic [19:0]  u2;
   logic [15:0]  rd_n      = 16'hffff;
   logic [15:0]  rd_q      = 16'hffff;
   logic [15:0]  mem [logic [19:0]];
   logic [15:0]  qt [16:52] = '{16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000, 16'h0040, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0016, 16'h0020, 16'h0000, 16'h0000, 16'h0004, 16'h0000,
      16'h000a, 16'h0000, 16'h0005, 16'h0000, 16'h0004, 16'h0000, 16'h0015, 16'h0002, 16'h0000, 16'h0000,
      16'h0000, 16'h0002, 16'h00ff, 16'h0001, 16'h0010, 16'h0000, 16'h001f, 16'h0000, 16'h0000, 16'h0001};
   assign u1 = byte_mode ? ADDR_UNLOCK1_BYTE : ADDR_UNLOCK1_WORD;
   assign u2 = byte_mode ? ADDR_UNLOCK2_BYTE : ADDR_UNLOCK2_WORD;
   // Write strobe; starts at 0 so no spurious edge at time zero
   always @* wr_act = (ce_n === 1'b0 && we_n === 1'b0 && oe_n === 1'b1);
   // Commands are taken as the write strobe ends
   always @(negedge wr_act) begin
      n_wr++;
      if (unl == 3) begin
         if (!PROT_MASK[addr[19:15]] || clear_hi)
            mem[addr] = (mem.exists(addr) ? mem[addr] : 16'hffff) & dq_in;
         unl = 0;
      end else if (dq_in[7:0] == CMD_RESET) begin
         mode = (mode == FCQ_QUERY && back_auto) ? FCQ_AUTO : FCQ_ARRAY;
         unl = 0;
      end else if (dq_in[7:0] == CMD_QUERY && mode != FCQ_QUERY &&
                   addr == (byte_mode ? ADDR_QUERY_BYTE : ADDR_QUERY_WORD)) begin
         back_auto = (mode == FCQ_AUTO);
         mode = FCQ_QUERY;
      end else if (unl == 0 && addr == u1 && dq_in[7:0] == CMD_UNLOCK1)
         unl = 1;
      else if (unl == 1 && addr == u2 && dq_in[7:0] == CMD_UNLOCK2)
         unl = 2;
      else if (unl == 2 && addr == u1 && dq_in[7:0] == 8'ha0)
         unl = 3;
      else if (unl == 2 && addr == u1 && dq_in[7:0] == 8'h90) begin
         mode = FCQ_AUTO;
         unl = 0;
      end else
         unl = 0;
   end
   // Read value; table reads never touch the array
   always @(addr or mode or n_wr or byte_mode) begin
      w = byte_mode ? addr[7:1] : addr[6:0];
      if (mode == FCQ_QUERY && |(addr >> (byte_mode ? 8 : 7)))
         rd_n = 16'ha5a5;
      else if (mode == FCQ_QUERY)
         rd_n = (w >= 7'h10 && w <= 7'h34) ? qt[w] : 16'h0000;
      else if (mode == FCQ_AUTO)
         rd_n = AUTO_CODE;
      else
         rd_n = mem.exists(addr) ? mem[addr] : 16'hffff;
   end
   // New data after the access time, latched in between
   always @(rd_n) rd_q <= #(ACCESS_TIME_NS) rd_n;
   // Sleep follows address stability alone, strobes play no part
   always @(addr) t_chg = $time;
   always #10 asleep = ($time - t_chg >= ACCESS_TIME_NS + SLEEP_EXTRA_NS);
   // Released bus shows the inverse, so a badly timed sample cannot pass
   assign dq_out = (ce_n === 1'b0 && oe_n === 1'b0) ? rd_q : ~rd_q;
endmodule  // fcq_flash_model

// ==== bench/tb_fcq_host.sv ====
// Self-checking bench for the flash query and unprotect host.
// Assumes the behavioural flash model and the design package.
module tb_fcq_host import fcq_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************************************
   // Signals, rows and tasks
   // ****************************************************************
   localparam logic [15:0] AUTO = 16'h00c3;  // Arbitrary autoselect code
   logic        ref_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        req_valid = 1'b0;
   fcq_op_type  req_op = FCQ_OP_READ;
   logic [19:0] req_addr = 20'h00000;
   logic [15:0] req_wdata = 16'h0000;
   logic        byte_mode = 1'b0;
   logic        unprotect_req = 1'b0;
   logic        req_ready, rsp_valid, clear_elevated_req, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
   logic [15:0] rsp_rdata, flash_dq_o, dev_dq, dq_wire, rd;
   logic [19:0] flash_addr;
   int          n_mismatch = 0;
   int          checked = 0;
   logic [31:0] rows [37] = '{32'h00100051, 32'h00110052, 32'h00120059, 32'h00130002, 32'h00140000,
      32'h00150040, 32'h00160000, 32'h00170000, 32'h00180000, 32'h00190000, 32'h001a0000, 32'h001b0016,
      32'h001c0020, 32'h001d0000, 32'h001e0000, 32'h001f0004, 32'h00200000, 32'h0021000a, 32'h00220000,
      32'h00230005, 32'h00240000, 32'h00250004, 32'h00260000, 32'h00270015, 32'h00280002, 32'h00290000,
      32'h002a0000, 32'h002b0000, 32'h002c0002, 32'h002d00ff, 32'h002e0001, 32'h002f0010, 32'h00300000,
      32'h0031001f, 32'h00320000, 32'h00330000, 32'h00340001};
   always #20 ref_clk = ~ref_clk;
   // Whoever enables drives the shared data wire
   assign dq_wire = flash_dq_oe ? flash_dq_o : dev_dq;
   fcq_host i_fcq_host (.ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
      .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .byte_mode(byte_mode),
      .unprotect_req(unprotect_req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .clear_elevated_req(clear_elevated_req), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
      .flash_dq_oe(flash_dq_oe), .flash_dq_i(dq_wire), .flash_ce_n(flash_ce_n),
      .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
   fcq_flash_model #(.AUTO_CODE(AUTO)) i_fcq_flash_model (.addr(flash_addr), .dq_in(dq_wire),
      .dq_out(dev_dq), .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .byte_mode(byte_mode),
      .clear_hi(clear_elevated_req));
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Request held until taken; answer waited for under a bound
   task automatic op(input fcq_op_type o, input logic [19:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req_op <= o;
      req_addr <= a;
      req_wdata <= d;
      do begin
         @(negedge ref_clk);
         n++;
      end while (req_ready !== 1'b1 && n < 100);
      @(posedge ref_clk);
      req_valid <= 1'b0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 200);
      if (n >= 200) begin
         n_mismatch++;
         $display("MISMATCH t=%0t no answer", $time);
      end
      rd = rsp_rdata;
   endtask
   task automatic rd_chk(input logic [19:0] a, input logic [15:0] exp, input string what);
      op(FCQ_OP_READ, a, 16'h0000);
      check(rd, exp, what);
   endtask
   task automatic wr(input logic [19:0] a, input logic [15:0] d);
      op(FCQ_OP_WRITE_RAW, a, d);
   endtask
   task automatic pin(input logic v);
      @(posedge ref_clk);
      unprotect_req <= v;
      repeat (6) @(negedge ref_clk);
      check({15'h0000, clear_elevated_req}, {15'h0000, v}, "elevated request");
   endtask
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      rd_chk(20'h00100, 16'hffff, "erased array");
      op(FCQ_OP_QUERY, 20'h00000, 16'h0000);
      foreach (rows[i]) rd_chk({4'h0, rows[i][31:16]}, rows[i][15:0], "table");
      rd_chk(20'h00110, 16'h0051, "upper bits masked");
      $display("test table done");
      op(FCQ_OP_RESET, 20'h00000, 16'h0000);
      rd_chk(20'h00010, 16'hffff, "array after exit");
      op(FCQ_OP_PROGRAM, 20'h00100, 16'h1234);
      rd_chk(20'h00100, 16'h1234, "programmed");
      wr(ADDR_UNLOCK1_WORD, 16'h00a0);
      wr(20'h00200, 16'h0000);
      rd_chk(20'h00200, 16'hffff, "no unlock");
      $display("test program done");
      // Protected block: refused, taken while elevated, refused again
      op(FCQ_OP_PROGRAM, 20'h08010, 16'h0000);
      rd_chk(20'h08010, 16'hffff, "protected");
      pin(1'b1);
      op(FCQ_OP_PROGRAM, 20'h08010, 16'h00ff);
      rd_chk(20'h08010, 16'h00ff, "unprotected");
      pin(1'b0);
      op(FCQ_OP_PROGRAM, 20'h08020, 16'h0000);
      rd_chk(20'h08020, 16'hffff, "protected again");
      $display("test unprotect done");
      // Autoselect, table from there, reset back to autoselect
      wr(ADDR_UNLOCK1_WORD, 16'h00aa);
      wr(ADDR_UNLOCK2_WORD, 16'h0055);
      wr(ADDR_UNLOCK1_WORD, 16'h0090);
      rd_chk(20'h00000, AUTO, "autoselect");
      op(FCQ_OP_QUERY, 20'h00000, 16'h0000);
      rd_chk(20'h00011, 16'h0052, "table from autoselect");
      op(FCQ_OP_RESET, 20'h00000, 16'h0000);
      rd_chk(20'h00000, AUTO, "back to autoselect");
      op(FCQ_OP_RESET, 20'h00000, 16'h0000);
      $display("test autoselect done");
      // Long stable address: data stays latched, new address gives new data
      rd_chk(20'h00100, 16'h1234, "before sleep");
      repeat (10) @(negedge ref_clk);
      rd_chk(20'h00100, 16'h1234, "after sleep");
      rd_chk(20'h00101, 16'hffff, "new address");
      @(posedge ref_clk);
      byte_mode <= 1'b1;
      op(FCQ_OP_QUERY, 20'h00000, 16'h0000);
      rd_chk(20'h00024, 16'h0059, "byte table");
      op(FCQ_OP_RESET, 20'h00000, 16'h0000);
      rd_chk(20'h00100, 16'h1234, "array intact");
      $display("test sleep and byte mode done");
      // Mid-run reset: pins parked and idle, then a request right after release
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (2) @(negedge ref_clk);
      check({11'h000, req_ready, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe}, 16'h001e, "reset pins");
      check({13'h0000, clear_elevated_req, rsp_valid, |flash_addr}, 16'h0000, "reset idle");
      @(posedge ref_clk);
      nrst <= 1'b1;
      rd_chk(20'h00100, 16'h1234, "after reset");
      $display("test reset done");
      results();
   end
   // Whole run is near 25 us; a hang is cut off well after
   initial begin
      #400000;
      n_mismatch++;
      $display("MISMATCH t=%0t watchdog", $time);
      results();
   end
endmodule  // tb_fcq_host
